/* File: hw/fault_sup_pkg.sv */
// Package for the drive fault supervisor: scales, codes, timing counts.
// Assumes values are signed 16-bit, 100% = 16384.
package fault_sup_pkg;
	localparam int VW = 16; // Value width
	localparam int FULL_SCALE = 16384; // 100 percent
	localparam int CLK_MHZ = 100; // mclk rate
	localparam int MS_CYC = CLK_MHZ * 1000; // Cycles per millisecond
	localparam int NOCUR_MS = 500; // No-current delay
	localparam int SEL_MS = 500; // Selection ambiguity delay
	localparam int TACHO_MS = 20; // Tacho check period
	localparam int NOCUR_CYC = NOCUR_MS * MS_CYC;
	localparam int SEL_CYC = SEL_MS * MS_CYC;
	localparam int TACHO_CYC = TACHO_MS * MS_CYC;
	localparam int TACHO_FAILS = 3; // Consecutive failed checks
	// Fixed thresholds: percentages in full-scale units, angle, current, states
	localparam logic [15:0] PCT1 = 16'h00a4; // 1 percent
	localparam logic [15:0] PCT2 = 16'h0148; // 2 percent
	localparam logic [15:0] PCT0P4 = 16'h0042; // 0.4 percent
	localparam logic [15:0] PCT0P5 = 16'h0052; // 0.5 percent
	localparam logic [15:0] OVL110 = 16'h4d71; // 110 percent squared
	localparam logic [15:0] ANGLE_165 = 16'h0a50; // 165 deg, 1/16 deg
	localparam logic [15:0] MA3 = 16'h0bb8; // 3 mA in uA
	localparam logic [3:0] RUN_MAX = 4'h2; // Running states 0..2
	localparam logic [3:0] ST_06 = 4'h6; // Analog watch bound
	// Fault indices
	localparam int F_CUR = 0, F_EMF = 1, F_FLD = 2, F_STALL = 3;
	localparam int F_NOCUR = 4, F_I2T = 5, F_OVSPD = 6, F_PWR = 7;
	localparam int F_PWROFF = 8, F_SEL = 9, F_TACHO = 10, F_BRK = 11;
	localparam int F_AIN0 = 12, F_AIN1 = 13, NF = 14;
	localparam logic [15:0] D_SET = 16'h0001, D_OPT = 16'h0002;
	localparam logic [15:0] D_RAMP = 16'h0003;
	localparam logic [15:0] D_TDEF = 16'h0001, D_TPOL = 16'h0002;
	// Diagnostic memory: three words
	typedef struct packed {
		logic [15:0] w0;
		logic [15:0] w1;
		logic [15:0] w2;
	} diag_t;
	// Configuration limits and times
	typedef struct packed {
		logic [15:0] current_dev_limit;
		logic [31:0] current_dev_time;
		logic [15:0] emf_dev_limit;
		logic [31:0] emf_dev_time;
		logic [15:0] field_dev_limit;
		logic [31:0] field_dev_time;
		logic [31:0] stall_time;
		logic [15:0] max_speed_threshold;
		logic [15:0] power_i2t_max;
		logic [15:0] tacho_emf_enable_pct;
		logic [3:0] speed_polarity_setting;
		logic [15:0] rated_converter_current;
		logic [3:0] field_weakening_config;
		logic [3:0] main_input_config;
		logic [3:0] select_input1_config;
	} cfg_t;
endpackage

/* File: hw/drive_fault_supervisor.sv */
// Drive fault supervisor: limit and timer checks raising latched faults.
// Assumes measured values are synchronous to mclk, scaled to FULL_SCALE;
// binary select inputs arrive from pins and are synchronised here.
// Overview of operation
// - Current deviation over limit too long faults
// - EMF deviation over limit too long faults
// - EMF check off at positive field limit
// - Field deviation over limit too long faults
// - Limit, current, low speed too long: stall
// - Stability limit, no current 500 ms faults
// - Motor I2t at 110 percent level faults
// - Speed above threshold plus 0.5 percent
// - Power section I2t at maximum faults
// - Power lost with fault: store code
// - Ambiguous parameter set 0.5 s: code 1
// - Set changed during optimisation: code 2
// - Ramp sets 2 and 3 together: code 3
// - Every 20 ms check speed/EMF ratio
// - Tacho fault after three failed checks
// - Tacho check needs EMF and current
// - Tacho fault stores code, speed, EMF
// - Braking EMF fault on direction change
// - Braking fault stores angle and EMFs
// - Main input 4-20 mA below 3 mA
// - Select input 4-20 mA below 3 mA
// - Drive monitors only in running states
`timescale 1ns/1ns
module drive_fault_supervisor #(
	parameter int NOCUR_CYCLES = fault_sup_pkg::NOCUR_CYC,
	parameter int SEL_CYCLES = fault_sup_pkg::SEL_CYC,
	parameter int TACHO_CYCLES = fault_sup_pkg::TACHO_CYC
) (
	input wire logic mclk,
	input wire logic srst,
	input fault_sup_pkg::cfg_t cfg, // Limits and settings
	input wire logic [3:0] op_state, // Operating state
	input wire logic signed [15:0] cur_dev, // Current controller dev
	input wire logic signed [15:0] emf_dev, // EMF controller deviation
	input wire logic signed [15:0] fld_dev, // Field controller dev
	input wire logic field_at_pos_limit, // Field setpoint at + limit
	input wire logic torque_limit_hit, // Torque or current limit
	input wire logic [15:0] arm_current, // Armature current magnitude
	input wire logic signed [15:0] speed_actual, // Speed actual value
	input wire logic signed [15:0] speed_actual_overspeed,
	input wire logic signed [15:0] emf_actual, // EMF actual value
	input wire logic [15:0] ideal_dc_voltage, // Full-conduction voltage
	input wire logic at_stability_limit, // Angle at rectifier limit
	input wire logic [15:0] motor_i2t, // Accumulated motor I2t
	input wire logic [15:0] power_i2t, // Power section I2t
	input wire logic pwr_lost_with_fault, // Power-up flag, saved
	input wire logic [15:0] last_fault_code, // Saved code from store
	input wire logic [2:0] param_set_sel, // Sets 2,3,4 pins
	input wire logic [1:0] ramp_set_sel, // Ramp sets 2,3 pins
	input wire logic optim_run, // Optimisation run active
	input wire logic dir_change_req, // Torque direction change pulse
	input wire logic torque_free_expired, // Torque-free interval done
	input wire logic parallel_drive_cmd, // Parallel drive in use
	input wire logic parallel_ready, // Parallel drive ready
	input wire logic signed [15:0] requested_armature_current,
	input wire logic signed [15:0] calc_firing_angle, // Unlimited
	input wire logic [15:0] main_input_ua, // Main input current
	input wire logic [15:0] sel1_input_ua, // Select 1 current
	input wire logic ack, // Acknowledge pulse
	output logic [13:0] fault, // Latched faults
	output logic fault_any, // Any fault present
	output fault_sup_pkg::diag_t sel_diag, // Selection diagnostics
	output fault_sup_pkg::diag_t tacho_diag, // Tacho diagnostics
	output fault_sup_pkg::diag_t brake_diag, // Braking diagnostics
	output fault_sup_pkg::diag_t pwr_diag, // Power-loss diagnostics
	output logic [1:0] active_param_set, // Unambiguous set index
	output logic [1:0] active_ramp_set // Unambiguous ramp set
);
	import fault_sup_pkg::*;

	// Absolute value of a signed word
	function automatic logic [15:0] absv(input logic signed [15:0] v);
		absv = v[15] ? 16'(-v) : 16'(v);
	endfunction
	// Percent-of-scale threshold from reference and 1/16384 fraction
	function automatic logic [15:0] frac(input logic [15:0] ref_v,
		input logic [15:0] f);
		logic [31:0] p;
		p = 32'(ref_v) * 32'(f);
		frac = p[29:14];
	endfunction

	// Pin synchronisers for the binary selects
	// Only the second stage is read, so a metastable first stage never
	// reaches the ambiguity decode.
	logic [4:0] sel_s1_q, sel_s2_q;
	always_ff @(posedge mclk) begin
		sel_s1_q <= {ramp_set_sel, param_set_sel};
		sel_s2_q <= sel_s1_q;
	end

	// Running window for drive monitors
	wire running = (op_state <= RUN_MAX);
	wire [15:0] rated1_w = frac(cfg.rated_converter_current, PCT1);
	wire [15:0] rated2_w = frac(cfg.rated_converter_current, PCT2);
	wire [15:0] rated05_w = frac(cfg.rated_converter_current, PCT0P5);
	wire [15:0] spd_lim_w = 16'(cfg.max_speed_threshold + PCT0P5);
	wire [15:0] tacho_emf_w = frac(ideal_dc_voltage,
		16'(({16'h0, cfg.tacho_emf_enable_pct} * FULL_SCALE) / 100));

	// Conditions for timed monitors
	wire [4:0] tcond; // One bit per timed monitor
	assign tcond[0] = running && absv(cur_dev) > cfg.current_dev_limit;
	assign tcond[1] = running && !field_at_pos_limit
		&& absv(emf_dev) > cfg.emf_dev_limit;
	assign tcond[2] = running && absv(fld_dev) > cfg.field_dev_limit;
	assign tcond[3] = running && torque_limit_hit
		&& arm_current > rated1_w && absv(speed_actual) < PCT0P4;
	assign tcond[4] = running && at_stability_limit
		&& arm_current < rated1_w;
	wire [31:0] tlim [5];
	assign tlim[0] = cfg.current_dev_time;
	assign tlim[1] = cfg.emf_dev_time;
	assign tlim[2] = cfg.field_dev_time;
	assign tlim[3] = cfg.stall_time;
	assign tlim[4] = 32'(NOCUR_CYCLES);

	// Per-monitor duration counters; expire when time exceeded
	logic [31:0] tcnt_q [5];
	logic [4:0] texp;
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 5; i++) begin
			if (srst || !tcond[i])
				tcnt_q[i] <= 32'h0000_0000;
			else if (tcnt_q[i] <= tlim[i])
				tcnt_q[i] <= tcnt_q[i] + 32'h0000_0001;
		end
	end
	always_comb begin
		for (int i = 0; i < 5; i++)
			texp[i] = tcond[i] && (tcnt_q[i] > tlim[i]);
	end

	// Selection ambiguity tracking
	wire [2:0] ps = sel_s2_q[2:0];
	wire [1:0] rs = sel_s2_q[4:3];
	wire ps_amb = (ps[0] & ps[1]) | (ps[0] & ps[2]) | (ps[1] & ps[2]);
	wire rs_amb = rs[0] & rs[1];
	wire [1:0] ps_idx = ps[2] ? 2'd3 : ps[1] ? 2'd2 : ps[0] ? 2'd1 : 2'd0;
	wire [1:0] rs_idx = rs[1] ? 2'd2 : rs[0] ? 2'd1 : 2'd0;
	logic [1:0] opt_set_q;
	logic optim_q;
	wire opt_chg = optim_run && optim_q && (active_param_set != opt_set_q);
	logic [31:0] ps_cnt_q, rs_cnt_q, oc_cnt_q;
	wire ps_exp = ps_amb && ps_cnt_q > 32'(SEL_CYCLES);
	wire rs_exp = rs_amb && rs_cnt_q > 32'(SEL_CYCLES);
	wire oc_exp = opt_chg && oc_cnt_q > 32'(SEL_CYCLES);

	// Selection timers and last unambiguous sets
	always_ff @(posedge mclk) begin
		if (srst) begin
			ps_cnt_q <= 32'h0000_0000;
			rs_cnt_q <= 32'h0000_0000;
			oc_cnt_q <= 32'h0000_0000;
			active_param_set <= 2'h0;
			active_ramp_set <= 2'h0;
			opt_set_q <= 2'h0;
			optim_q <= 1'b0;
		end else begin
			ps_cnt_q <= ps_amb ? ps_cnt_q + {31'h0, !ps_exp} : 32'h0;
			rs_cnt_q <= rs_amb ? rs_cnt_q + {31'h0, !rs_exp} : 32'h0;
			oc_cnt_q <= opt_chg ? oc_cnt_q + {31'h0, !oc_exp} : 32'h0;
			if (!ps_amb)
				active_param_set <= ps_idx;
			if (!rs_amb)
				active_ramp_set <= rs_idx;
			optim_q <= optim_run;
			if (optim_run && !optim_q)
				opt_set_q <= active_param_set;
		end
	end

	// Tacho check, every period while enabled
	wire [15:0] spd_pol = cfg.speed_polarity_setting[3] ?
		16'(-speed_actual) : 16'(speed_actual);
	// Ratio > 5%: speed*20 > emf, in signed arithmetic
	wire signed [21:0] spd20 = 22'($signed(spd_pol)) * 22'sd20;
	wire ratio_ok = spd20 > 22'($signed(emf_actual));
	wire tacho_en = running
		&& emf_actual > $signed({1'b0, tacho_emf_w[14:0]})
		&& arm_current > rated2_w;
	logic [31:0] tp_cnt_q;
	logic [1:0] tfail_q;
	wire tick = (tp_cnt_q == 32'(TACHO_CYCLES - 1));
	wire tacho_trip = tick && tacho_en && !ratio_ok
		&& tfail_q == 2'(TACHO_FAILS - 1);
	always_ff @(posedge mclk) begin
		if (srst) begin
			tp_cnt_q <= 32'h0000_0000;
			tfail_q <= 2'h0;
		end else begin
			tp_cnt_q <= tick ? 32'h0 : tp_cnt_q + 32'h0000_0001;
			if (tick)
				tfail_q <= (tacho_en && !ratio_ok && !tacho_trip) ?
					tfail_q + 2'h1 : 2'h0;
		end
	end

	// Braking EMF conditions on direction change
	wire brk_trip = running && dir_change_req
		&& cfg.field_weakening_config[2:0] == 3'h0
		&& torque_free_expired
		&& (!parallel_drive_cmd || parallel_ready)
		&& absv(requested_armature_current) > rated05_w
		&& calc_firing_angle > $signed(ANGLE_165);

	// Raw fault events
	wire [NF-1:0] ev; // One bit per fault source
	assign ev[F_CUR] = texp[0];
	assign ev[F_EMF] = texp[1];
	assign ev[F_FLD] = texp[2];
	assign ev[F_STALL] = texp[3];
	assign ev[F_NOCUR] = texp[4];
	assign ev[F_I2T] = running && motor_i2t >= OVL110;
	assign ev[F_OVSPD] = running
		&& $signed(speed_actual_overspeed) > $signed(spd_lim_w);
	assign ev[F_PWR] = running && power_i2t >= cfg.power_i2t_max;
	assign ev[F_PWROFF] = pwr_lost_with_fault;
	assign ev[F_SEL] = ps_exp | rs_exp | oc_exp;
	assign ev[F_TACHO] = tacho_trip;
	assign ev[F_BRK] = brk_trip;
	assign ev[F_AIN0] = op_state <= ST_06 && cfg.main_input_config[0]
		&& main_input_ua < MA3;
	assign ev[F_AIN1] = cfg.select_input1_config[0]
		&& sel1_input_ua < MA3;

	// Fault latches: set wins over acknowledge
	always_ff @(posedge mclk) begin
		if (srst)
			fault <= '0;
		else
			fault <= ev | (fault & {NF{!ack}});
	end
	assign fault_any = |fault;

	// Diagnostic words, captured on the first raising of the selection, tacho, braking and power-loss faults
	always_ff @(posedge mclk) begin
		if (srst) begin
			sel_diag <= '0;
			tacho_diag <= '0;
			brake_diag <= '0;
			pwr_diag <= '0;
		end else begin
			if (ev[F_SEL] && !fault[F_SEL])
				sel_diag.w0 <= ps_exp ? D_SET : oc_exp ? D_OPT : D_RAMP;
			if (tacho_trip && !fault[F_TACHO])
				tacho_diag <= '{w0: (spd20 < 0 && emf_actual > 0) ?
					D_TPOL : D_TDEF, w1: speed_actual, w2: emf_actual};
			if (brk_trip && !fault[F_BRK])
				brake_diag <= '{w0: calc_firing_angle, w1: emf_actual,
					w2: emf_actual};
			if (pwr_lost_with_fault && !fault[F_PWROFF])
				pwr_diag.w0 <= last_fault_code;
		end
	end

	// Assertions
	AST_CUR: assert property (@(posedge mclk) disable iff (srst)
		texp[0] |=> fault[F_CUR]) else $error("current fault missed");
	AST_EMF_SUP: assert property (@(posedge mclk) disable iff (srst)
		field_at_pos_limit && !fault[F_EMF] |=> !fault[F_EMF])
		else $error("emf not suppressed");
	AST_FLD: assert property (@(posedge mclk) disable iff (srst)
		texp[2] |=> fault[F_FLD]) else $error("field fault missed");
	AST_RUN: assert property (@(posedge mclk) disable iff (srst)
		!running |-> !ev[F_STALL] && !ev[F_TACHO])
		else $error("monitor out of state");
	AST_LATCH: assert property (@(posedge mclk) disable iff (srst)
		fault[F_OVSPD] && !ack |=> fault[F_OVSPD])
		else $error("fault dropped without ack");
	AST_OVSPD: assert property (@(posedge mclk) disable iff (srst)
		ev[F_OVSPD] |=> fault[F_OVSPD]) else $error("overspeed missed");
	AST_TACHO3: assert property (@(posedge mclk) disable iff (srst)
		tacho_trip |-> tfail_q == 2'd2) else $error("tacho early");
	AST_BRK: assert property (@(posedge mclk) disable iff (srst)
		brk_trip && !fault[F_BRK]
		|=> brake_diag.w0 == $past(calc_firing_angle))
		else $error("brake diag wrong");
	AST_STALL: assert property (@(posedge mclk) disable iff (srst)
		texp[3] |=> fault[F_STALL])
		else $error("stall fault missed");
	AST_PWR: assert property (@(posedge mclk) disable iff (srst)
		pwr_lost_with_fault |=> fault[F_PWROFF])
		else $error("power loss fault missed");
	AST_SEL_KEEP: assert property (@(posedge mclk) disable iff (srst)
		ps_amb |=> active_param_set == $past(active_param_set))
		else $error("set changed while ambiguous");
	AST_TACHO_DIAG: assert property (@(posedge mclk) disable iff (srst)
		tacho_trip && !fault[F_TACHO]
		|=> tacho_diag.w1 == $past(speed_actual))
		else $error("tacho speed not stored");
	AST_AIN: assert property (@(posedge mclk) disable iff (srst)
		ev[F_AIN0] |=> fault[F_AIN0]) else $error("main input missed");

	// Cover points for the main scenarios
	COV_TACHO: cover property (@(posedge mclk) tacho_trip);
	COV_STALL: cover property (@(posedge mclk) ev[F_STALL]);
	COV_OPT: cover property (@(posedge mclk) oc_exp);
	COV_BRK: cover property (@(posedge mclk) brk_trip);
	COV_SEL: cover property (@(posedge mclk) ps_exp);
endmodule // drive_fault_supervisor

/* File: verification/drive_fault_supervisor_test.sv */
// Self-checking bench for the drive fault supervisor.
// Assumes shortened timers; inputs driven at falling edge.
`timescale 1ns/1ns
module drive_fault_supervisor_test;
	import fault_sup_pkg::*;
	localparam int NCY = 50, SCY = 50, TCY = 20; // Shortened timers
	logic mclk = 1'b0, srst = 1'b1, ack;
	cfg_t cfg;
	logic [3:0] op_state;
	logic signed [15:0] cur_dev, emf_dev, fld_dev, speed_actual, emf_actual;
	logic signed [15:0] speed_actual_overspeed, requested_armature_current;
	logic signed [15:0] calc_firing_angle;
	logic field_at_pos_limit, torque_limit_hit, at_stability_limit;
	logic pwr_lost_with_fault, optim_run, dir_change_req;
	logic torque_free_expired, parallel_drive_cmd, parallel_ready;
	logic [15:0] arm_current, ideal_dc_voltage, motor_i2t, power_i2t;
	logic [15:0] last_fault_code, main_input_ua, sel1_input_ua, v;
	logic [2:0] param_set_sel;
	logic [1:0] ramp_set_sel, active_param_set, active_ramp_set;
	logic [13:0] fault;
	logic fault_any;
	diag_t sel_diag, tacho_diag, brake_diag, pwr_diag;
	int fails = 0, samples_checked = 0, tt = 8, ticks = 0;
	drive_fault_supervisor #(.NOCUR_CYCLES(NCY), .SEL_CYCLES(SCY),
		.TACHO_CYCLES(TCY)) i_dut (.mclk(mclk), .srst(srst), .cfg(cfg),
		.op_state(op_state), .cur_dev(cur_dev), .emf_dev(emf_dev),
		.fld_dev(fld_dev), .field_at_pos_limit(field_at_pos_limit),
		.torque_limit_hit(torque_limit_hit), .arm_current(arm_current),
		.speed_actual(speed_actual),
		.speed_actual_overspeed(speed_actual_overspeed),
		.emf_actual(emf_actual), .ideal_dc_voltage(ideal_dc_voltage),
		.at_stability_limit(at_stability_limit), .motor_i2t(motor_i2t),
		.power_i2t(power_i2t), .pwr_lost_with_fault(pwr_lost_with_fault),
		.last_fault_code(last_fault_code), .param_set_sel(param_set_sel),
		.ramp_set_sel(ramp_set_sel), .optim_run(optim_run),
		.dir_change_req(dir_change_req),
		.torque_free_expired(torque_free_expired),
		.parallel_drive_cmd(parallel_drive_cmd),
		.parallel_ready(parallel_ready),
		.requested_armature_current(requested_armature_current),
		.calc_firing_angle(calc_firing_angle),
		.main_input_ua(main_input_ua), .sel1_input_ua(sel1_input_ua),
		.ack(ack), .fault(fault), .fault_any(fault_any),
		.sel_diag(sel_diag), .tacho_diag(tacho_diag),
		.brake_diag(brake_diag), .pwr_diag(pwr_diag),
		.active_param_set(active_param_set),
		.active_ramp_set(active_ramp_set));
	// Free-running clock
	always #5 mclk = ~mclk;
	// Cuts a hang short
	always @(posedge mclk) begin
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			fails = fails + 1;
			close_out();
		end
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Quiet inputs: no monitor condition true
	task automatic idle;
		cfg = '0;
		cfg.current_dev_limit = 16'h03e8;
		cfg.emf_dev_limit = 16'h03e8;
		cfg.field_dev_limit = 16'h03e8;
		{cfg.current_dev_time, cfg.emf_dev_time} = {tt, tt};
		{cfg.field_dev_time, cfg.stall_time} = {tt, tt};
		cfg.max_speed_threshold = 16'h3000;
		cfg.power_i2t_max = 16'h2000;
		cfg.tacho_emf_enable_pct = 16'h000a; // Plain percent, 10
		cfg.rated_converter_current = 16'h4000;
		cfg.field_weakening_config = 4'h1;
		{op_state, cur_dev, emf_dev, fld_dev, speed_actual} = '0;
		{emf_actual, speed_actual_overspeed, calc_firing_angle} = '0;
		{requested_armature_current, ack, dir_change_req} = '0;
		{field_at_pos_limit, torque_limit_hit, at_stability_limit} = '0;
		{pwr_lost_with_fault, optim_run, torque_free_expired} = '0;
		{parallel_drive_cmd, parallel_ready, arm_current} = '0;
		{motor_i2t, power_i2t, last_fault_code, param_set_sel} = '0;
		{ramp_set_sel, main_input_ua, sel1_input_ua} = '0;
		ideal_dc_voltage = 16'h4000;
	endtask
	// Quiet inputs, then acknowledge and expect all faults gone
	task automatic clear(input string nm);
		idle();
		cyc(3);
		ack = 1'b1;
		cyc(1);
		ack = 1'b0;
		cyc(1);
		chk("fault_cleared", 16'h0000, {2'b00, fault});
		chk("fault_any_clr", 16'h0000, {15'h0, fault_any});
		$display("test %s done", nm);
	endtask
	// Timed monitor: silent before its time, set shortly after
	task automatic timed(input int idx, input int t);
		cyc(t - 1);
		chk("timed_early", 16'h0000, {15'h0, fault[idx]});
		cyc(8);
		chk("timed_late", 16'h0001, {15'h0, fault[idx]});
		chk("fault_any_set", 16'h0001, {15'h0, fault_any});
	endtask
	// Level monitor: after three cycles, fault bit matches expected level
	task automatic lvl(input int idx, input logic on);
		cyc(3);
		chk("level_fault", {15'h0, on}, {15'h0, fault[idx]});
	endtask
	initial begin
		void'($urandom(32'h996668eb));
		idle();
		cyc(4);
		srst = 1'b0;
		cyc(1);
		chk("rst_fault", 16'h0000, {2'b00, fault});
		v = sel_diag.w0 | tacho_diag.w0 | pwr_diag.w0 | brake_diag.w0;
		chk("rst_diag", 16'h0000, v);
		$display("test reset done");
		// Current deviation, negative sign, random time and size
		tt = 5 + $urandom % 12;
		idle();
		cur_dev = -(16'sh03e9 + $signed({1'b0, 15'($urandom % 500)}));
		timed(F_CUR, tt);
		cur_dev = '0;
		cyc(4);
		chk("cur_latched", 16'h0001, {15'h0, fault[F_CUR]});
		clear("current");
		// Not running: current monitor stays silent
		op_state = 4'h3;
		cur_dev = 16'sh0500;
		cyc(tt + 8);
		chk("cur_not_run", 16'h0000, {15'h0, fault[F_CUR]});
		clear("state");
		// EMF monitor suppressed at positive field limit
		field_at_pos_limit = 1'b1;
		emf_dev = 16'sh0500;
		cyc(tt + 8);
		chk("emf_supp", 16'h0000, {15'h0, fault[F_EMF]});
		field_at_pos_limit = 1'b0;
		timed(F_EMF, tt);
		clear("emf");
		fld_dev = -16'sh0400;
		timed(F_FLD, tt);
		clear("field");
		{torque_limit_hit, arm_current} = {1'b1, 16'h00c8};
		timed(F_STALL, tt);
		clear("stall");
		at_stability_limit = 1'b1;
		timed(F_NOCUR, NCY);
		clear("nocur");
		// Boundaries of the level monitors
		v = 16'h3000 + PCT0P5;
		speed_actual_overspeed = v;
		lvl(F_OVSPD, 1'b0);
		speed_actual_overspeed = v + 16'h0001;
		lvl(F_OVSPD, 1'b1);
		clear("overspeed");
		motor_i2t = OVL110 - 16'h0001;
		lvl(F_I2T, 1'b0);
		motor_i2t = OVL110;
		lvl(F_I2T, 1'b1);
		clear("motor_i2t");
		power_i2t = 16'h1fff;
		lvl(F_PWR, 1'b0);
		power_i2t = 16'h2000;
		lvl(F_PWR, 1'b1);
		clear("power_i2t");
		// Power lost with a fault pending
		v = 16'($urandom);
		{pwr_lost_with_fault, last_fault_code} = {1'b1, v};
		lvl(F_PWROFF, 1'b1);
		chk("pwr_code", v, pwr_diag.w0);
		clear("pwr_lost");
		// Ambiguous parameter set, last clear set kept
		param_set_sel = 3'b010;
		cyc(6);
		param_set_sel = 3'b110;
		cyc(SCY - 6);
		chk("set_kept", 16'h0002, {14'h0, active_param_set});
		chk("set_early", 16'h0000, {15'h0, fault[F_SEL]});
		cyc(14);
		chk("set_code", D_SET, sel_diag.w0);
		clear("param_set");
		// Set changed during an optimisation run
		param_set_sel = 3'b001;
		cyc(4);
		optim_run = 1'b1;
		cyc(6);
		param_set_sel = 3'b100;
		cyc(SCY - 6);
		chk("opt_early", 16'h0000, {15'h0, fault[F_SEL]});
		cyc(20);
		chk("opt_code", D_OPT, sel_diag.w0);
		clear("optim");
		ramp_set_sel = 2'b01;
		cyc(6);
		ramp_set_sel = 2'b11;
		cyc(SCY - 6);
		chk("ramp_kept", 16'h0001, {14'h0, active_ramp_set});
		cyc(14);
		chk("ramp_code", D_RAMP, sel_diag.w0);
		clear("ramp");
		// Tacho wrong polarity: negative speed, positive EMF
		{emf_actual, arm_current} = {16'sh3000, 16'h0400};
		speed_actual = -16'sh0800 - 16'($urandom % 256);
		cyc(TCY + 2);
		chk("tacho_early", 16'h0000, {15'h0, fault[F_TACHO]});
		cyc(3 * TCY);
		chk("tacho_flt", 16'h0001, {15'h0, fault[F_TACHO]});
		chk("tacho_code", D_TPOL, tacho_diag.w0);
		chk("tacho_spd", speed_actual, tacho_diag.w1);
		chk("tacho_emf", emf_actual, tacho_diag.w2);
		clear("tacho");
		// Negated speed polarity, then a dead tacho
		cfg.speed_polarity_setting = 4'h8;
		{emf_actual, arm_current} = {16'sh3000, 16'h0400};
		speed_actual = -16'sh0800 - 16'($urandom % 256);
		cyc(4 * TCY);
		chk("tacho_neg", 16'h0000, {15'h0, fault[F_TACHO]});
		speed_actual = '0;
		cyc(4 * TCY);
		chk("tacho_dead", 16'h0001, {15'h0, fault[F_TACHO]});
		chk("tacho_def", D_TDEF, tacho_diag.w0);
		clear("tacho_pol");
		// Braking EMF on a direction change, angle boundary
		cfg.field_weakening_config = 4'h0;
		{torque_free_expired, parallel_ready, emf_actual} = {2'b11, 16'sh2000};
		requested_armature_current = 16'sh00c8;
		for (int k = 0; k < 2; k++) begin
			calc_firing_angle = ANGLE_165 + 16'(k);
			dir_change_req = 1'b1;
			cyc(1);
			dir_change_req = 1'b0;
			lvl(F_BRK, k[0]);
		end
		chk("brk_angle", ANGLE_165 + 16'h0001, brake_diag.w0);
		chk("brk_emf", 16'h2000, brake_diag.w1);
		chk("brk_emf_flt", 16'h2000, brake_diag.w2);
		clear("brake");
		// Analog inputs below 3 mA
		{cfg.main_input_config, op_state} = {4'h1, 4'h7};
		main_input_ua = MA3 - 16'h0001 - 16'($urandom % 100);
		lvl(F_AIN0, 1'b0);
		op_state = ST_06;
		lvl(F_AIN0, 1'b1);
		clear("main_input");
		{cfg.select_input1_config, sel1_input_ua} = {4'h1, MA3};
		lvl(F_AIN1, 1'b0);
		sel1_input_ua = MA3 - 16'h0001;
		lvl(F_AIN1, 1'b1);
		clear("select_input");
		close_out();
	end
endmodule // drive_fault_supervisor_test
